// file: logic/psq_sequencer.sv
// Purpose: program-flow core: interrupt vectoring, table reads, return stack
// Assumes: the core supplies next-pc, call/return strobes and table commands on clk_sys
// Notes: ROM is external; a table read issues rom_addr then captures rom_data a cycle later
//
// Contract
// - timer 0 overflow vectors to 0008H
// - timer 1 overflow vectors to 000CH
// - enabled RTC timeout vectors to 0014H
// - dialer pin edges request vector 18H
// - current page read uses pc page
// - last page read uses all-ones page
// - low byte to memory, high byte held
// - wide variant page from high pointer
// - table pointers readable and writable
// - table high byte is read only
// - table read takes two cycles
// - hidden stack of 12/8/4 levels
// - call/interrupt push, returns pop
// - reset leaves stack empty
// - full stack withholds interrupt acknowledge
// - call on full stack drops oldest
// - vectors in bank 0, full address saved
`timescale 1ns/10ps
module psq_sequencer
#(
  parameter int DEPTH = 12,
  parameter int PCW = 14,
  parameter bit WIDE = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [psq_pkg::PC_W-1:0] pc_now,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic return_from_interrupt_req,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic rtc_timeout,
  input wire logic rtc_enable,
  input wire logic int_global_en,
  input wire logic hook_switch_input,
  input wire logic hold_line_input,
  input wire logic hands_free_input,
  input wire logic tabrd_cur,
  input wire logic tabrd_last,
  input wire logic [7:0] tab_dest,
  input wire logic [15:0] rom_data,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq_take,
  output logic [psq_pkg::PC_W-1:0] irq_vector,
  output logic [psq_pkg::PC_W-1:0] ret_pc,
  output logic ret_valid,
  output logic [psq_pkg::PC_W-1:0] rom_addr,
  output logic rom_rd,
  output logic tab_wr,
  output logic [7:0] tab_wr_addr,
  output logic [7:0] tab_wr_data,
  output logic tab_busy,
  output logic stack_full,
  output logic irq_out
);
  import psq_pkg::*;
  localparam int SPW = $clog2(DEPTH + 1);
  // elaboration-time check: only the three stack depths and 12..14 address bits exist
  if (!(DEPTH == 12 || DEPTH == 8 || DEPTH == 4) || PCW < 12 || PCW > PC_W)
  begin : g_bad_cfg
    $error("psq_sequencer: unsupported DEPTH or PCW");
  end
  // mask address to the variant's width
  function automatic logic [PC_W-1:0] pc_mask(input logic [PC_W-1:0] a);
    logic [PC_W-1:0] m;
    m = '1;
    m = m >> (PC_W - PCW);
    pc_mask = a & m;
  endfunction : pc_mask

  // pin synchronisers and edge detectors
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_d;
  logic [2:0] pin_ok;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_d <= 3'h0;
      pin_ok <= 3'h0;
    end
    else
    begin
      pin_s1 <= {hands_free_input, hold_line_input, hook_switch_input};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      pin_ok <= {pin_ok[1:0], 1'b1}; // reset zeros in pin_d would fake edges on high pins
    end
  end
  logic dialer_evt;
  assign dialer_evt = pin_ok[2] & ((pin_s2[0] ^ pin_d[0])  // any hook edge
                      | (~pin_s2[1] & pin_d[1])            // hold falling
                      | (pin_s2[2] & ~pin_d[2]));          // hands-free rising

  // interrupt request flags and mask
  logic [N_IRQ-1:0] int_stat;
  logic [N_IRQ-1:0] int_mask;
  logic [N_IRQ-1:0] evt;
  logic [N_IRQ-1:0] ack_clr;
  always_comb
  begin
    evt = '0;
    evt[IRQ_TMR0] = tmr0_ovf;
    evt[IRQ_TMR1] = tmr1_ovf;
    evt[IRQ_RTC] = rtc_timeout & rtc_enable;
    evt[IRQ_DIALER] = dialer_evt;
  end
  // stack storage and index
  logic [PC_W-1:0] stk [DEPTH];
  logic [SPW-1:0] sp;
  logic full_now;
  assign full_now = (sp == SPW'(DEPTH));

  // pick highest priority pending enabled request
  logic [N_IRQ-1:0] pend;
  logic [N_IRQ-1:0] pick;
  logic [PC_W-1:0] pick_vec;
  logic do_ack;
  always_comb
  begin
    pend = int_stat & int_mask;
    pick = '0;
    pick_vec = VEC_RESET;
    if (pend[IRQ_TMR0])
    begin
      pick[IRQ_TMR0] = 1'b1;
      pick_vec = VEC_TMR0;
    end
    else if (pend[IRQ_TMR1])
    begin
      pick[IRQ_TMR1] = 1'b1;
      pick_vec = VEC_TMR1;
    end
    else if (pend[IRQ_RTC])
    begin
      pick[IRQ_RTC] = 1'b1;
      pick_vec = VEC_RTC;
    end
    else if (pend[IRQ_DIALER])
    begin
      pick[IRQ_DIALER] = 1'b1;
      pick_vec = VEC_DIALER;
    end
    // full stack holds acknowledge; call/return own the stack this cycle
    do_ack = int_global_en & (|pend) & ~full_now & ~call_req & ~ret_req & ~return_from_interrupt_req
             & ~irq_take;
    ack_clr = do_ack ? pick : '0;
  end

  // flag set wins over a software clear in the same cycle
  logic [N_IRQ-1:0] wclr;
  assign wclr = (reg_wr && reg_addr == ADDR_INT_STAT) ? reg_wdata[N_IRQ-1:0] : '0;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      int_stat <= RST_IRQ;
    else
      int_stat <= (int_stat & ~wclr & ~ack_clr) | evt; // flag kept while stack full
  end
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      int_mask <= RST_IRQ;
    else if (reg_wr && reg_addr == ADDR_INT_MASK)
      int_mask <= reg_wdata[N_IRQ-1:0];
  end
  // acknowledge outputs: vector always in bank 0
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      irq_take <= 1'b0;
      irq_vector <= VEC_RESET;
    end
    else
    begin
      irq_take <= do_ack;
      irq_vector <= pick_vec;   // upper bits zero, so bank 0
    end
  end
  // return stack: shift register so overflow drops the oldest entry
  logic push;
  logic pop;
  assign push = call_req | do_ack;
  assign pop = (ret_req | return_from_interrupt_req) & ~call_req;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      sp <= '0;                                   // empty after reset
    else if (push && !full_now)
      sp <= sp + SPW'(1);
    else if (pop && sp != '0)
      sp <= sp - SPW'(1);                         // frees a level for held interrupts
  end
  // entry 0 is the most recent; full push shifts the oldest out
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
        stk[i] <= VEC_RESET;
    end
    else if (push)
    begin
      stk[0] <= pc_mask(pc_now);                  // full address incl. bank
      for (int i = 1; i < DEPTH; i++)
        stk[i] <= stk[i-1];
    end
    else if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        stk[i] <= stk[i+1];
      stk[DEPTH-1] <= VEC_RESET;
    end
  end
  // restored pc offered one cycle after the return
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ret_pc <= VEC_RESET;
      ret_valid <= 1'b0;
    end
    else
    begin
      ret_pc <= stk[0];
      ret_valid <= pop && sp != '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      stack_full <= 1'b0;
    else
      stack_full <= full_now; // status only; index itself is not on the register port
  end

  // table pointer registers
  logic [7:0] tpl;
  logic [7:0] tph;
  logic [7:0] thb;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      tpl <= RST_BYTE;
      tph <= RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_TPL)
        tpl <= reg_wdata;
      if (WIDE && reg_addr == ADDR_TPH)
        tph <= reg_wdata;
    end
  end

  // table read sequencer: fetch cycle then capture cycle
  psq_state_t st;
  logic [PC_W-1:0] next_taddr;
  always_comb
  begin
    logic [PC_W-1:0] hi;
    hi = '0;
    if (tabrd_last)
      hi = '1;                                    // last page all ones
    else if (WIDE)
      hi = PC_W'({tph[5:0], 8'h00});              // any page of any bank
    else
      hi = pc_now & ~PC_W'(8'hFF);                // current pc page
    next_taddr = pc_mask({hi[PC_W-1:PAGE_W], tpl});
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st <= PSQ_IDLE;
      rom_addr <= VEC_RESET;
      rom_rd <= 1'b0;
      tab_wr <= 1'b0;
      tab_wr_addr <= RST_BYTE;
      tab_wr_data <= RST_BYTE;
      tab_busy <= 1'b0;
      thb <= RST_BYTE;
    end
    else
    begin
      rom_rd <= 1'b0;
      tab_wr <= 1'b0;
      case (st)
        PSQ_IDLE:
        begin
          if (tabrd_cur || tabrd_last)
          begin
            rom_addr <= next_taddr;
            rom_rd <= 1'b1;
            tab_wr_addr <= tab_dest;
            tab_busy <= 1'b1;
            st <= PSQ_TFETCH;                     // first of two cycles
          end
        end
        PSQ_TFETCH:
        begin
          tab_wr <= 1'b1;
          tab_wr_data <= rom_data[7:0];           // low byte to memory
          thb <= rom_data[15:8];                  // only writer of the high byte
          st <= PSQ_TDONE;                        // second cycle
        end
        PSQ_TDONE:
        begin
          tab_busy <= 1'b0;
          st <= PSQ_IDLE;
        end
        default:
          st <= PSQ_IDLE;
      endcase
    end
  end

  // register read port, data one cycle later; unmapped reads zero
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      reg_rdata <= RST_BYTE;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_TPL: reg_rdata <= tpl;
        ADDR_THB: reg_rdata <= thb;
        ADDR_TPH: reg_rdata <= WIDE ? tph : RST_BYTE;
        ADDR_INT_STAT: reg_rdata <= {4'h0, int_stat};
        ADDR_INT_MASK: reg_rdata <= {4'h0, int_mask};
        default: reg_rdata <= RST_BYTE;
      endcase
    end
    else
      reg_rdata <= RST_BYTE;
  end

  // level interrupt while any unmasked flag is set
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      irq_out <= 1'b0;
    else
      irq_out <= |(int_stat & int_mask);
  end
endmodule : psq_sequencer

// file: include/psq_pkg.sv
// Purpose: constants for the program sequencer (vectors, table reads, return stack)
// Assumes: 14-bit program address, 8-bit data memory bus
// Notes: data-memory offsets double as the register port addresses
package psq_pkg;
  localparam int PC_W = 14;
  localparam int PAGE_W = 8;  // one page = 256 words
  localparam logic [PC_W-1:0] VEC_RESET = 14'h0000;
  localparam logic [PC_W-1:0] VEC_TMR0 = 14'h0008;
  localparam logic [PC_W-1:0] VEC_TMR1 = 14'h000C;
  localparam logic [PC_W-1:0] VEC_RTC = 14'h0014;
  localparam logic [PC_W-1:0] VEC_DIALER = 14'h0018;
  localparam logic [7:0] ADDR_TPL = 8'h07;
  localparam logic [7:0] ADDR_THB = 8'h08;
  localparam logic [7:0] ADDR_TPH = 8'h1F;
  localparam logic [7:0] ADDR_INT_STAT = 8'h1C;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1D;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_IRQ = 4'h0;
  localparam int IRQ_TMR0 = 0;
  localparam int IRQ_TMR1 = 1;
  localparam int IRQ_RTC = 2;
  localparam int IRQ_DIALER = 3;
  localparam int N_IRQ = 4;
  typedef enum logic [2:0] {
    PSQ_IDLE = 3'b001,
    PSQ_TFETCH = 3'b010,
    PSQ_TDONE = 3'b100
  } psq_state_t;
endpackage : psq_pkg

// file: sim/psq_seq_monitor.sv
// Purpose: port assertions for psq_sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: attached to every psq_sequencer by bind
`timescale 1ns/10ps
module psq_seq_monitor
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic tabrd_cur,
  input wire logic tabrd_last,
  input wire logic tab_busy,
  input wire logic rom_rd,
  input wire logic tab_wr,
  input wire logic [psq_pkg::PC_W-1:0] rom_addr,
  input wire logic irq_take,
  input wire logic [psq_pkg::PC_W-1:0] irq_vector,
  input wire logic stack_full,
  input wire logic ret_valid,
  input wire logic ret_req,
  input wire logic return_from_interrupt_req,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // an accepted read fetches, writes back, then frees the port
  sequence s_go;
    (tabrd_cur || tabrd_last) && !tab_busy;
  endsequence
  sequence s_run;
    rom_rd && tab_busy ##1 tab_wr ##1 !tab_busy;
  endsequence
  AST_TREAD: assert property (s_go |=> s_run)
    else $error("table read length wrong");
  AST_TLAST: assert property (tabrd_last && !tab_busy |=> rom_addr[13:8] == 6'h3F)
    else $error("last page bits wrong");
  AST_TWR: assert property (tab_wr |-> tab_busy && !rom_rd)
    else $error("write-back outside read");
  AST_VEC: assert property (irq_take |-> irq_vector[13:5] == 9'h000)
    else $error("vector outside bank 0");
  AST_GAP: assert property (irq_take |=> !irq_take)
    else $error("acks back to back");
  AST_FULL: assert property (stack_full |-> !irq_take)
    else $error("ack with full stack");
  AST_RET: assert property (ret_valid |-> $past(ret_req) || $past(return_from_interrupt_req))
    else $error("pop without return");
  AST_RDZ: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
endmodule : psq_seq_monitor

bind psq_sequencer psq_seq_monitor mon_u (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .tabrd_cur(tabrd_cur),
  .tabrd_last(tabrd_last),
  .tab_busy(tab_busy),
  .rom_rd(rom_rd),
  .tab_wr(tab_wr),
  .rom_addr(rom_addr),
  .irq_take(irq_take),
  .irq_vector(irq_vector),
  .stack_full(stack_full),
  .ret_valid(ret_valid),
  .ret_req(ret_req),
  .return_from_interrupt_req(return_from_interrupt_req),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

// file: sim/tb.sv
// Purpose: self-checking bench for psq_sequencer
// Assumes: depth 4 stack, wide table pointer
// Notes: ret_req and rtc_enable are tied
`timescale 1ns/10ps
module tb;
  import psq_pkg::*;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [PC_W-1:0] pc_now = 14'h0000;
  logic call_req = 1'h0, ret_req = 1'h0, return_from_interrupt_req = 1'h0, int_global_en = 1'h0;
  logic rtc_enable = 1'h1, tabrd_cur = 1'h0, tabrd_last = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic hook_switch_input = 1'h0, hold_line_input = 1'h1, hands_free_input = 1'h0;
  logic [3:0] ev = 4'h0;
  logic [7:0] tab_dest = 8'h47, reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [15:0] rom_data = 16'h0000;
  logic [7:0] reg_rdata, tab_wr_addr, tab_wr_data;
  logic irq_take, ret_valid, rom_rd, tab_wr, tab_busy, stack_full, irq_out;
  logic [PC_W-1:0] irq_vector, ret_pc, rom_addr;
  int err_total = 0;
  int n_tests = 0;
  // event pulses share one vector so one task drives them all
  wire tmr0_ovf = ev[0];
  wire tmr1_ovf = ev[1];
  wire rtc_timeout = ev[2];
  psq_sequencer #(.DEPTH(4)) dut_u (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pc_now(pc_now),
    .call_req(call_req),
    .ret_req(ret_req),
    .return_from_interrupt_req(return_from_interrupt_req),
    .tmr0_ovf(tmr0_ovf),
    .tmr1_ovf(tmr1_ovf),
    .rtc_timeout(rtc_timeout),
    .rtc_enable(rtc_enable),
    .int_global_en(int_global_en),
    .hook_switch_input(hook_switch_input),
    .hold_line_input(hold_line_input),
    .hands_free_input(hands_free_input),
    .tabrd_cur(tabrd_cur),
    .tabrd_last(tabrd_last),
    .tab_dest(tab_dest),
    .rom_data(rom_data),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq_take(irq_take),
    .irq_vector(irq_vector),
    .ret_pc(ret_pc),
    .ret_valid(ret_valid),
    .rom_addr(rom_addr),
    .rom_rd(rom_rd),
    .tab_wr(tab_wr),
    .tab_wr_addr(tab_wr_addr),
    .tab_wr_data(tab_wr_data),
    .tab_busy(tab_busy),
    .stack_full(stack_full),
    .irq_out(irq_out)
  );
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic tk;
    @(posedge clk_sys);
    #1;
  endtask : tk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 4'h0;
  endtask : pulse
  task automatic call(input logic [PC_W-1:0] p);
    @(posedge clk_sys);
    pc_now <= p;
    call_req <= 1'h1;
    @(posedge clk_sys);
    call_req <= 1'h0;
  endtask : call
  task automatic pop(input logic w, input logic [PC_W-1:0] e);
    @(posedge clk_sys);
    return_from_interrupt_req <= 1'h1;
    @(posedge clk_sys);
    return_from_interrupt_req <= 1'h0;
    #1;
    chk(ret_valid, w);
    if (w)
      chk(ret_pc, e);
  endtask : pop
  // bounded wait; running out ends the run
  task automatic take(input logic [PC_W-1:0] v);
    for (int i = 0; i < 12 && irq_take !== 1'h1; i++)
      tk();
    chk(irq_take, 1'h1);
    chk(irq_vector, v);
    if (irq_take !== 1'h1)
      finish_test();
  endtask : take
  task automatic none(input int n);
    repeat (n)
    begin
      tk();
      chk(irq_take, 1'h0);
    end
  endtask : none
  task automatic t_stack;
    pop(1'h0, 14'h0000);
    for (int i = 0; i < 5; i++)
      call(14'h0100 + 14'(i));
    tk(); // full flag is registered one edge after the fourth push
    chk(stack_full, 1'h1);
    wr(ADDR_INT_MASK, 8'h0F);
    int_global_en <= 1'h1;
    pulse(4'h1);
    none(6);
    @(posedge clk_sys);
    pc_now <= 14'h2ABC;
    pop(1'h1, 14'h0104);
    take(VEC_TMR0);
    pop(1'h1, 14'h2ABC);
    for (int i = 3; i > 0; i--)
      pop(1'h1, 14'h0100 + 14'(i));
    pop(1'h0, 14'h0000);
  endtask : t_stack
  task automatic t_regs;
    wr(ADDR_TPL, 8'h5A);
    rd(ADDR_TPL, 8'h5A);
    wr(ADDR_TPH, 8'h2B);
    rd(ADDR_TPH, 8'h2B);
    wr(ADDR_THB, 8'hFF);
    rd(ADDR_THB, 8'h00);
    rd(8'h30, 8'h00);
  endtask : t_regs
  task automatic tread(input logic l, input logic [PC_W-1:0] a, input logic [15:0] w);
    @(posedge clk_sys);
    rom_data <= w;
    tabrd_cur <= !l;
    tabrd_last <= l;
    @(posedge clk_sys);
    tabrd_cur <= 1'h0;
    tabrd_last <= 1'h0;
    #1;
    chk(rom_addr, a);
    tk();
    chk(tab_wr_data, w[7:0]);
    chk(tab_wr_addr, tab_dest);
    rd(ADDR_THB, w[15:8]);
  endtask : tread
  task automatic t_table;
    int_global_en <= 1'h0;
    tread(1'h0, 14'h2B5A, 16'hC33C);
    tread(1'h1, 14'h3F5A, 16'h1EE1);
    wr(ADDR_THB, 8'h00);
    rd(ADDR_THB, 8'h1E);
  endtask : t_table
  task automatic t_mask;
    int_global_en <= 1'h0;
    pulse(4'h2);
    tk();
    chk(irq_out, 1'h1);
    rd(ADDR_INT_STAT, 8'h02);
    wr(ADDR_INT_STAT, 8'h02);
    rd(ADDR_INT_STAT, 8'h00);
    chk(irq_out, 1'h0);
    wr(ADDR_INT_MASK, 8'h00);
    pulse(4'h1);
    tk();
    chk(irq_out, 1'h0);
    wr(ADDR_INT_STAT, 8'h01);
    wr(ADDR_INT_MASK, 8'h0F);
  endtask : t_mask
  task automatic t_irq;
    logic [PC_W-1:0] vt[3] = '{VEC_TMR0, VEC_TMR1, VEC_RTC};
    logic [2:0] pv[6] = '{3'h6, 3'h4, 3'h6, 3'h7, 3'h3, 3'h2};
    logic pw[6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    int_global_en <= 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      pulse(4'h1 << i);
      take(vt[i]);
      pop(1'h1, pc_now);
    end
    pulse(4'h3);
    take(VEC_TMR0);
    pop(1'h1, pc_now);
    take(VEC_TMR1);
    pop(1'h1, pc_now);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys);
      {hook_switch_input, hold_line_input, hands_free_input} <= pv[i];
      if (pw[i])
      begin
        take(VEC_DIALER);
        pop(1'h1, pc_now);
      end
      else
        none(8);
    end
  endtask : t_irq
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'h1;
    t_stack();
    t_regs();
    t_table();
    t_mask();
    t_irq();
    finish_test();
  end
endmodule : tb
